// ==== rtl/ccaq_regs.vh ====
/*
 * register map, field positions, reset values and action codes of the
 * counter-compare and action-qualifier stage.
 * assumes a 32-bit axi4-lite slave; each register index is a word, the
 * byte address is four times the index.
 */
`ifndef CCAQ_REGS_VH
`define CCAQ_REGS_VH

// register indices (byte address = index * 4)
`define CCAQ_IDX_CMP_CTRL 12'h007
`define CCAQ_IDX_COMPARE_A_VALUE_FRAC 12'h008
`define CCAQ_IDX_COMPARE_A_VALUE 12'h009
`define CCAQ_IDX_COMPARE_B_VALUE 12'h00a
`define CCAQ_IDX_AQ_CTRL_A 12'h00b
`define CCAQ_IDX_AQ_CTRL_B 12'h00c
`define CCAQ_IDX_FORCE_ONCE 12'h00d
`define CCAQ_IDX_FORCE_CONT 12'h00e
`define CCAQ_IDX_COMPARE_A_VALUE_FRAC_MIR 12'h02c
`define CCAQ_IDX_COMPARE_A_VALUE_MIR 12'h02d
`define CCAQ_IDX_MODE 12'h030

// compare_control fields
`define CCAQ_CC_LOADA_LSB 0
`define CCAQ_CC_LOADB_LSB 2
`define CCAQ_CC_DIRA_BIT 4
`define CCAQ_CC_DIRB_BIT 6
`define CCAQ_CC_PENDA_BIT 8
`define CCAQ_CC_PENDB_BIT 9
`define CCAQ_CC_RESET 16'h0000

// load event choices
`define CCAQ_LD_ZERO 2'h0
`define CCAQ_LD_PERIOD 2'h1
`define CCAQ_LD_EITHER 2'h2

// action codes
`define CCAQ_ACT_NONE 2'h0
`define CCAQ_ACT_CLEAR 2'h1
`define CCAQ_ACT_SET 2'h2
`define CCAQ_ACT_TOGGLE 2'h3

// action control fields (2 bits each)
`define CCAQ_AQ_ZRO_LSB 0
`define CCAQ_AQ_PRD_LSB 2
`define CCAQ_AQ_CAU_LSB 4
`define CCAQ_AQ_CAD_LSB 6
`define CCAQ_AQ_CBU_LSB 8
`define CCAQ_AQ_CBD_LSB 10
`define CCAQ_AQ_RESET 16'h0000

// one-time force fields
`define CCAQ_FO_ACTA_LSB 0
`define CCAQ_FO_GOA_BIT 2
`define CCAQ_FO_ACTB_LSB 3
`define CCAQ_FO_GOB_BIT 5
`define CCAQ_FO_RELD_LSB 6
`define CCAQ_FO_RESET 16'h0000

// continuous force fields: 0 off, 1 low, 2 high
`define CCAQ_FC_A_LSB 0
`define CCAQ_FC_B_LSB 2
`define CCAQ_FC_RESET 16'h0000

// counter modes
`define CCAQ_MODE_UP 2'h0
`define CCAQ_MODE_DOWN 2'h1
`define CCAQ_MODE_UPDOWN 2'h2
`define CCAQ_MODE_FROZEN 2'h3

// axi responses
`define CCAQ_RESP_OKAY 2'h0
`define CCAQ_RESP_SLVERR 2'h2

`endif

// ==== rtl/ccaq_top.v ====
/*
 * counter-compare and action-qualifier stage: shadowed compare values,
 * compare events, prioritised action qualification and two registered
 * pwm outputs, with an axi4-lite register slave.
 * assumes the time-base counter, period, direction and mode come from
 * logic on the same clock; period and zero flags are derived here.
 */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccaq_regs.vh"

module ccaq_top #(
  parameter CW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // time base
  input wire [CW-1:0] time_base_count,
  input wire [CW-1:0] time_base_period,
  input wire count_dir_up,
  input wire [1:0] count_mode,
  // events and outputs
  output wire count_at_zero,
  output wire count_at_period,
  output wire count_at_compare_a,
  output wire count_at_compare_b,
  output wire count_dir_out,
  output reg pwm_out_a,
  output reg pwm_out_b,
  // axi4-lite write address
  input wire [13:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [13:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ************************************************
  // registers
  // ************************************************
  reg [15:0] cmp_ctrl;
  reg [15:0] compare_a_value_frac;
  reg [CW-1:0] compare_a_value_act;
  reg [CW-1:0] compare_a_value_shd;
  reg [CW-1:0] compare_b_value_act;
  reg [CW-1:0] compare_b_value_shd;
  reg pend_a;
  reg pend_b;
  reg [15:0] action_ctrl_out_a;
  reg [15:0] action_ctrl_out_b;
  reg [15:0] force_once;
  reg [3:0] force_cont_shd;
  reg [3:0] force_cont_act;

  wire [1:0] load_a = cmp_ctrl[`CCAQ_CC_LOADA_LSB +: 2];
  wire [1:0] load_b = cmp_ctrl[`CCAQ_CC_LOADB_LSB +: 2];
  wire compare_a_direct_select = cmp_ctrl[`CCAQ_CC_DIRA_BIT];
  wire compare_b_direct_select = cmp_ctrl[`CCAQ_CC_DIRB_BIT];
  wire [1:0] reload_sel = force_once[`CCAQ_FO_RELD_LSB +: 2];

  // ************************************************
  // functions
  // ************************************************
  function load_hit;
    input [1:0] sel;
    input zero;
    input prd;
    begin
      case (sel)
        `CCAQ_LD_ZERO: load_hit = zero;
        `CCAQ_LD_PERIOD: load_hit = prd;
        `CCAQ_LD_EITHER: load_hit = zero | prd;
        default: load_hit = 1'b0;
      endcase
    end
  endfunction

  function [1:0] field;
    input [15:0] r;
    input integer lsb;
    begin
      field = r[lsb +: 2];
    end
  endfunction

  // later actions in the list override earlier ones
  function [1:0] pick;
    input [1:0] cur;
    input ev;
    input [1:0] act;
    begin
      pick = (ev && act != `CCAQ_ACT_NONE) ? act : cur;
    end
  endfunction

  function apply;
    input lvl;
    input [1:0] act;
    begin
      case (act)
        `CCAQ_ACT_CLEAR: apply = 1'b0;
        `CCAQ_ACT_SET: apply = 1'b1;
        `CCAQ_ACT_TOGGLE: apply = ~lvl;
        default: apply = lvl;
      endcase
    end
  endfunction

  // ************************************************
  // compare events
  // ************************************************
  wire run = count_mode != `CCAQ_MODE_FROZEN;
  reg [CW-1:0] last_count;
  wire moved = time_base_count != last_count;
  wire ev_zero = run && moved && time_base_count == {CW{1'b0}};
  wire ev_prd = run && moved && time_base_count == time_base_period;
  // one event per counter value: a held count does not re-fire
  wire eq_a = run && moved && time_base_count == compare_a_value_act;
  wire eq_b = run && moved && time_base_count == compare_b_value_act;
  wire up_m = count_mode == `CCAQ_MODE_UP;
  // compare above period gives no event in up mode, even when a loaded count equals it
  wire ok_a = !(up_m && compare_a_value_act > time_base_period);
  wire ok_b = !(up_m && compare_b_value_act > time_base_period);
  wire ev_a = eq_a && ok_a;
  wire ev_b = eq_b && ok_b;
  // direction seen with each event; zero/period turnarounds in up-down
  // mode count once since the counter value occurs only once there
  wire dir_up = up_m ? 1'b1 :
    (count_mode == `CCAQ_MODE_DOWN) ? 1'b0 : count_dir_up;
  assign count_at_zero = ev_zero;
  assign count_at_period = ev_prd;
  assign count_at_compare_a = ev_a;
  assign count_at_compare_b = ev_b;
  assign count_dir_out = dir_up;

  // ************************************************
  // action qualifier
  // ************************************************
  reg [1:0] act_a;
  reg [1:0] act_b;
  wire go_a = force_once[`CCAQ_FO_GOA_BIT];
  wire go_b = force_once[`CCAQ_FO_GOB_BIT];

  function [1:0] qualify;
    input [15:0] c;
    input up;
    input zero;
    input prd;
    input ca;
    input cb;
    input [1:0] mode;
    reg [1:0] r;
    begin
      r = `CCAQ_ACT_NONE;
      if (mode == `CCAQ_MODE_DOWN) begin
        r = pick(r, prd, field(c, `CCAQ_AQ_PRD_LSB));
        r = pick(r, ca, field(c, `CCAQ_AQ_CAD_LSB));
        r = pick(r, cb, field(c, `CCAQ_AQ_CBD_LSB));
        r = pick(r, zero, field(c, `CCAQ_AQ_ZRO_LSB));
      end else if (mode == `CCAQ_MODE_UP) begin
        r = pick(r, zero, field(c, `CCAQ_AQ_ZRO_LSB));
        r = pick(r, ca, field(c, `CCAQ_AQ_CAU_LSB));
        r = pick(r, cb, field(c, `CCAQ_AQ_CBU_LSB));
        r = pick(r, prd, field(c, `CCAQ_AQ_PRD_LSB));
      end else if (up) begin
        r = pick(r, zero, field(c, `CCAQ_AQ_ZRO_LSB));
        r = pick(r, ca, field(c, `CCAQ_AQ_CAU_LSB));
        r = pick(r, cb, field(c, `CCAQ_AQ_CBU_LSB));
        r = pick(r, prd, field(c, `CCAQ_AQ_PRD_LSB));
      end else begin
        r = pick(r, prd, field(c, `CCAQ_AQ_PRD_LSB));
        r = pick(r, ca, field(c, `CCAQ_AQ_CAD_LSB));
        r = pick(r, cb, field(c, `CCAQ_AQ_CBD_LSB));
        r = pick(r, zero, field(c, `CCAQ_AQ_ZRO_LSB));
      end
      qualify = r;
    end
  endfunction

  always @* begin
    // cross switch: any event to any action on either output
    act_a = qualify(action_ctrl_out_a, dir_up, ev_zero, ev_prd, ev_a, ev_b,
      count_mode);
    act_b = qualify(action_ctrl_out_b, dir_up, ev_zero, ev_prd, ev_a, ev_b,
      count_mode);
    if (go_a)
      act_a = force_once[`CCAQ_FO_ACTA_LSB +: 2];
    if (go_b)
      act_b = force_once[`CCAQ_FO_ACTB_LSB +: 2];
  end

  wire [1:0] fca = force_cont_act[`CCAQ_FC_A_LSB +: 2];
  wire [1:0] fcb = force_cont_act[`CCAQ_FC_B_LSB +: 2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out_a <= 1'b0;
      pwm_out_b <= 1'b0;
      last_count <= {CW{1'b1}};
    end else begin
      last_count <= time_base_count;
      // continuous force overrides all other actions
      if (fca == 2'h1 || fca == 2'h2)
        pwm_out_a <= fca[1];
      else
        pwm_out_a <= apply(pwm_out_a, act_a);
      if (fcb == 2'h1 || fcb == 2'h2)
        pwm_out_b <= fcb[1];
      else
        pwm_out_b <= apply(pwm_out_b, act_b);
    end
  end

  // ************************************************
  // axi4-lite slave
  // ************************************************
  reg aw_held;
  reg w_held;
  reg [11:0] aw_idx;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_now = aw_held || s_axi_awvalid;
  wire w_now = w_held || s_axi_wvalid;
  wire do_wr = aw_now && w_now && !s_axi_bvalid;
  wire [11:0] wi = aw_held ? aw_idx : s_axi_awaddr[13:2];
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;

  function mapped;
    input [11:0] i;
    begin
      mapped = (i >= `CCAQ_IDX_CMP_CTRL && i <= `CCAQ_IDX_FORCE_CONT) ||
        i == `CCAQ_IDX_COMPARE_A_VALUE_FRAC_MIR || i == `CCAQ_IDX_COMPARE_A_VALUE_MIR ||
        i == `CCAQ_IDX_MODE;
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  wire wr_ctl = do_wr && wi == `CCAQ_IDX_CMP_CTRL;
  wire wr_compare_a_value = do_wr && (wi == `CCAQ_IDX_COMPARE_A_VALUE || wi == `CCAQ_IDX_COMPARE_A_VALUE_MIR);
  wire wr_compare_b_value = do_wr && wi == `CCAQ_IDX_COMPARE_B_VALUE;
  wire wr_frac = do_wr &&
    (wi == `CCAQ_IDX_COMPARE_A_VALUE_FRAC || wi == `CCAQ_IDX_COMPARE_A_VALUE_FRAC_MIR);
  wire [15:0] compare_a_value_old = compare_a_direct_select ? compare_a_value_act : compare_a_value_shd;
  wire [15:0] compare_b_value_old = compare_b_direct_select ? compare_b_value_act : compare_b_value_shd;
  wire [15:0] compare_a_value_new = merge(compare_a_value_old, wd, ws);
  wire [15:0] compare_b_value_new = merge(compare_b_value_old, wd, ws);
  wire ld_a = !compare_a_direct_select &&
    load_hit(load_a, ev_zero, ev_prd);
  wire ld_b = !compare_b_direct_select &&
    load_hit(load_b, ev_zero, ev_prd);
  wire fc_load = load_hit(reload_sel, ev_zero, ev_prd);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCAQ_RESP_OKAY;
      cmp_ctrl <= `CCAQ_CC_RESET;
      compare_a_value_frac <= 16'h0000;
      compare_a_value_act <= {CW{1'b0}};
      compare_a_value_shd <= {CW{1'b0}};
      compare_b_value_act <= {CW{1'b0}};
      compare_b_value_shd <= {CW{1'b0}};
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      action_ctrl_out_a <= `CCAQ_AQ_RESET;
      action_ctrl_out_b <= `CCAQ_AQ_RESET;
      force_once <= `CCAQ_FO_RESET;
      force_cont_shd <= 4'h0;
      force_cont_act <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wi) ? `CCAQ_RESP_OKAY : `CCAQ_RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // one-time force go bits self-clear after one cycle
      force_once[`CCAQ_FO_GOA_BIT] <= 1'b0;
      force_once[`CCAQ_FO_GOB_BIT] <= 1'b0;
      if (wr_ctl)
        cmp_ctrl <= merge(cmp_ctrl, wd, ws) & 16'h005f;
      if (wr_frac)
        compare_a_value_frac <= merge(compare_a_value_frac, wd, ws);
      // shadow path: load on chosen event, pending set wins over load
      if (ld_a) begin
        compare_a_value_act <= compare_a_value_shd;
        pend_a <= 1'b0;
      end
      if (ld_b) begin
        compare_b_value_act <= compare_b_value_shd;
        pend_b <= 1'b0;
      end
      if (wr_compare_a_value) begin
        if (compare_a_direct_select)
          compare_a_value_act <= compare_a_value_new;
        else begin
          compare_a_value_shd <= compare_a_value_new;
          pend_a <= 1'b1;
        end
      end
      if (wr_compare_b_value) begin
        if (compare_b_direct_select)
          compare_b_value_act <= compare_b_value_new;
        else begin
          compare_b_value_shd <= compare_b_value_new;
          pend_b <= 1'b1;
        end
      end
      if (do_wr && wi == `CCAQ_IDX_AQ_CTRL_A)
        action_ctrl_out_a <= merge(action_ctrl_out_a, wd, ws) & 16'h0fff;
      if (do_wr && wi == `CCAQ_IDX_AQ_CTRL_B)
        action_ctrl_out_b <= merge(action_ctrl_out_b, wd, ws) & 16'h0fff;
      if (do_wr && wi == `CCAQ_IDX_FORCE_ONCE)
        force_once <= merge(force_once, wd, ws) & 16'h00ff;
      if (do_wr && wi == `CCAQ_IDX_FORCE_CONT && ws[0])
        force_cont_shd <= wd[3:0];
      // continuous force shadow loads on its own chosen event
      if (fc_load)
        force_cont_act <= force_cont_shd;
      else if (reload_sel == 2'h3 && do_wr &&
          wi == `CCAQ_IDX_FORCE_CONT && ws[0])
        force_cont_act <= wd[3:0];
    end
  end

  // ************************************************
  // read path
  // ************************************************
  reg [15:0] rd_val;
  wire [11:0] ri = s_axi_araddr[13:2];
  always @* begin
    case (ri)
      `CCAQ_IDX_CMP_CTRL:
        rd_val = {6'h00, pend_b, pend_a, cmp_ctrl[7:0]};
      `CCAQ_IDX_COMPARE_A_VALUE_FRAC: rd_val = compare_a_value_frac;
      `CCAQ_IDX_COMPARE_A_VALUE: rd_val = compare_a_value_old;
      `CCAQ_IDX_COMPARE_B_VALUE: rd_val = compare_b_value_old;
      `CCAQ_IDX_AQ_CTRL_A: rd_val = action_ctrl_out_a;
      `CCAQ_IDX_AQ_CTRL_B: rd_val = action_ctrl_out_b;
      `CCAQ_IDX_FORCE_ONCE: rd_val = force_once & 16'h00db;
      `CCAQ_IDX_FORCE_CONT: rd_val = {12'h000, force_cont_shd};
      `CCAQ_IDX_COMPARE_A_VALUE_FRAC_MIR: rd_val = compare_a_value_frac;
      `CCAQ_IDX_COMPARE_A_VALUE_MIR: rd_val = compare_a_value_old;
      `CCAQ_IDX_MODE:
        rd_val = {13'h0000, pwm_out_b, pwm_out_a, dir_up};
      default: rd_val = 16'h0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CCAQ_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= mapped(ri) ? `CCAQ_RESP_OKAY : `CCAQ_RESP_SLVERR;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ==== sim/ccaq_top_assertions.sv ====
/* port checker for ccaq_top, attached by bind.
   assumes one aclk domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module ccaq_top_assertions #(
  parameter CW = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // time base
  input wire [CW-1:0] time_base_count,
  input wire [CW-1:0] time_base_period,
  input wire count_dir_up,
  input wire [1:0] count_mode,
  // events and outputs
  input wire count_at_zero,
  input wire count_at_period,
  input wire count_at_compare_a,
  input wire count_at_compare_b,
  input wire count_dir_out,
  input wire pwm_out_a,
  input wire pwm_out_b,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ****************************************
  // properties
  // ****************************************
  wire ev = count_at_zero | count_at_period | count_at_compare_a |
    count_at_compare_b;
  wire cause = ev | (s_axi_awvalid & s_axi_awready);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_done;
    s_axi_rvalid && s_axi_rready ##1 !s_axi_rvalid;
  endsequence
  a_zero_flag: assert property ($past(aresetn) |-> count_at_zero ==
    (time_base_count == 0 && time_base_count != $past(time_base_count)
    && count_mode != 2'h3)) else $error("zero flag wrong");
  a_period_flag: assert property ($past(aresetn) |->
    count_at_period == (time_base_count == time_base_period &&
    time_base_count != $past(time_base_count) && count_mode != 2'h3))
    else $error("period flag wrong");
  a_dir_qual: assert property (count_mode != 2'h3 |-> count_dir_out ==
    (count_mode == 2'h0 || (count_mode == 2'h2 && count_dir_up)))
    else $error("direction wrong");
  a_pwm_cause: assert property ($past(aresetn) &&
    (pwm_out_a != $past(pwm_out_a) || pwm_out_b != $past(pwm_out_b)) |->
    $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("pwm changed without cause");
  a_cmp_new: assert property ($past(aresetn) &&
    (count_at_compare_a || count_at_compare_b) |-> count_mode != 2'h3 &&
    time_base_count != $past(time_base_count))
    else $error("compare event on held count");
  a_reset_outs: assert property ($rose(aresetn) |-> !pwm_out_a &&
    !pwm_out_b && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  a_write_resp: assert property (wr_take |=> s_axi_bvalid ##1 !s_axi_bvalid)
    else $error("write response wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> rd_done)
    else $error("read answer wrong");
endmodule

bind ccaq_top ccaq_top_assertions #(.CW(CW)) u_ccaq_top_assertions (
  .aclk(aclk), .aresetn(aresetn), .time_base_count(time_base_count),
  .time_base_period(time_base_period), .count_dir_up(count_dir_up),
  .count_mode(count_mode), .count_at_zero(count_at_zero),
  .count_at_period(count_at_period), .count_at_compare_a(count_at_compare_a),
  .count_at_compare_b(count_at_compare_b), .count_dir_out(count_dir_out),
  .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// ==== sim/ccaq_tb_counter.sv ====
/* behavioural time-base counter feeding the compare stage.
   assumes mode codes 0 up, 1 down, 2 up-down, 3 frozen. */
`timescale 1ns/1ps
module ccaq_tb_counter (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire [1:0] mode,
  input wire [15:0] period,
  input wire load,
  input wire [15:0] load_val,
  // count
  output logic [15:0] count,
  output logic dir_up
);
  // ****************************************
  // counter
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
      dir_up <= 1'b1;
    end else if (load) begin
      // a jump may skip a compare value
      count <= load_val;
      dir_up <= 1'b1;
    end else if (mode == 2'h0) begin
      count <= (count >= period) ? 16'h0000 : count + 16'h0001;
    end else if (mode == 2'h1) begin
      count <= (count == 16'h0000) ? period : count - 16'h0001;
    end else if (mode == 2'h2) begin
      if (dir_up && count >= period) begin
        dir_up <= 1'b0;
        count <= count - 16'h0001;
      end else if (!dir_up && count == 16'h0000) begin
        dir_up <= 1'b1;
        count <= count + 16'h0001;
      end else begin
        count <= dir_up ? count + 16'h0001 : count - 16'h0001;
      end
    end
  end
endmodule

// ==== sim/test_ccaq_top.sv ====
/* self-checking bench for ccaq_top with a counter model and bus tasks.
   assumes the checker is bound and the design answers as its note says. */
`timescale 1ns/1ps
module test_ccaq_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ld = 1'b0;
  logic [1:0] md = 2'h3;
  logic [15:0] lv = 16'h0000;
  logic [15:0] sd = 16'h410a;
  logic [13:0] awa = 14'h0000;
  logic [13:0] ara = 14'h0000;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  wire [15:0] cnt;
  wire dup, awr, wrd, bv, arr, rv, pa, pb;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  logic [33:0] eq_r[$];
  logic [31:0] mq[$];
  logic [1:0] eq_b[$];
  logic [11:0] rl[10] = '{12'h007, 12'h008, 12'h009, 12'h00a, 12'h00b,
    12'h00c, 12'h00d, 12'h00e, 12'h02c, 12'h02d};
  int bad_count = 0;
  int n_checks = 0;

  ccaq_tb_counter u_ccaq_tb_counter (.aclk(aclk), .aresetn(aresetn),
    .mode(md), .period(16'h000a), .load(ld), .load_val(lv), .count(cnt),
    .dir_up(dup));
  ccaq_top u_ccaq_top (.aclk(aclk), .aresetn(aresetn),
    .time_base_count(cnt), .time_base_period(16'h000a), .count_dir_up(dup),
    .count_mode(md), .count_at_zero(), .count_at_period(),
    .count_at_compare_a(), .count_at_compare_b(), .count_dir_out(),
    .pwm_out_a(pa), .pwm_out_b(pb), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre));

  // ****************************************
  // helpers
  // ****************************************
  initial forever #5 aclk = ~aclk;

  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk_r(input [33:0] e, input [33:0] g, input [31:0] m);
    n_checks++;
    if ((g & {2'h3, m}) !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_b(input [1:0] e, input [1:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input [11:0] i, input [31:0] d, input [1:0] r = 2'h0);
    bit ta, tw, tb;
    eq_b.push_back(r);
    awa <= {i, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bre <= 1'b0;
    end while (!tb);
    @(posedge aclk);
  endtask

  task automatic rd(input [11:0] i, input [31:0] d,
      input [31:0] m = 32'hffffffff, input [1:0] r = 2'h0);
    bit ta, tb;
    eq_r.push_back({r, d & m});
    mq.push_back(m);
    ara <= {i, 2'h0};
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv && arr;
      tb = rv;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tb) rre <= 1'b0;
    end while (!tb);
    @(posedge aclk);
  endtask

  // load the counter, then run until count v is seen n times and freeze
  task automatic tld(input [15:0] v);
    ld <= 1'b1;
    lv <= v;
    @(posedge aclk);
    ld <= 1'b0;
  endtask

  task automatic run(input [1:0] m, input [15:0] v, input int n);
    md <= m;
    repeat (n) begin
      @(negedge aclk);
      while (cnt !== v) @(negedge aclk);
    end
    @(posedge aclk);
    md <= 2'h3;
    @(posedge aclk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // result monitor: takes the oldest note when a response appears
  initial forever begin
    @(negedge aclk);
    if (bv && bre) chk_b(eq_b.pop_front(), br);
    if (rv && rre) chk_r(eq_r.pop_front(), {rr, rdat}, mq.pop_front());
  end

  initial begin
    #500000;
    bad_count++;
    close_out;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rl[k]) rd(rl[k], 32'h0);
    rd(12'h030, 32'h0, 32'h6);
    rd(12'h00f, 32'h0, 32'hffffffff, 2'h2);
    wr(12'h00f, 32'h1, 2'h2);
    $display("test reset done");
    repeat (3) begin
      sd = lfsr(sd);
      wr(12'h008, {sd, sd});
      rd(12'h02c, {16'h0000, sd});
    end
    wr(12'h007, 32'h50);
    wr(12'h009, 32'h5);
    rd(12'h009, 32'h5);
    wr(12'h007, 32'h0);
    wr(12'h009, 32'h9);
    rd(12'h009, 32'h9);
    rd(12'h02d, 32'h9);
    rd(12'h007, 32'h100);
    $display("test shadow done");
    wr(12'h00b, 32'h12);
    tld(16'h0006);
    run(2'h0, 16'h0006, 2);
    rd(12'h030, 32'h2, 32'h6);
    rd(12'h007, 32'h0);
    run(2'h0, 16'h0009, 1);
    rd(12'h030, 32'h0, 32'h6);
    $display("test up done");
    wr(12'h007, 32'h50);
    wr(12'h009, 32'h3);
    wr(12'h00a, 32'h3);
    wr(12'h00b, 32'h122);
    run(2'h0, 16'h0004, 1);
    rd(12'h030, 32'h0, 32'h6);
    $display("test priority done");
    wr(12'h00b, 32'h60);
    wr(12'h00c, 32'hf0);
    wr(12'h009, 32'h4);
    tld(16'h0000);
    run(2'h2, 16'h0006, 1);
    rd(12'h030, 32'h6, 32'h6);
    run(2'h2, 16'h0002, 1);
    rd(12'h030, 32'h0, 32'h6);
    wr(12'h00b, 32'h0);
    wr(12'h009, 32'ha);
    run(2'h2, 16'h0005, 2);
    rd(12'h030, 32'h4, 32'h6);
    $display("test updown done");
    wr(12'h00c, 32'h0);
    wr(12'h00d, 32'h6);
    rd(12'h030, 32'h6, 32'h6);
    wr(12'h00d, 32'hc0);
    wr(12'h00e, 32'h1);
    rd(12'h030, 32'h4, 32'h6);
    rd(12'h00d, 32'hc0);
    wr(12'h00d, 32'h0);
    wr(12'h00e, 32'h2);
    rd(12'h030, 32'h4, 32'h6);
    rd(12'h00e, 32'h2);
    run(2'h0, 16'h0001, 1);
    rd(12'h030, 32'h6, 32'h6);
    $display("test force done");
    wr(12'h00d, 32'hc0);
    wr(12'h00e, 32'h0);
    wr(12'h009, 32'hc);
    wr(12'h00b, 32'h30);
    tld(16'h000c);
    run(2'h0, 16'h0001, 1);
    rd(12'h030, 32'h6, 32'h6);
    wr(12'h007, 32'h41);
    wr(12'h009, 32'h3);
    wr(12'h00b, 32'h40);
    run(2'h1, 16'h0000, 1);
    rd(12'h007, 32'h141);
    run(2'h1, 16'h0009, 2);
    rd(12'h007, 32'h41);
    run(2'h1, 16'h0002, 1);
    rd(12'h030, 32'h4, 32'h6);
    $display("test down done");
    close_out;
  end
endmodule
